// File: hdl/ldr_defines.svh
`ifndef LDR_DEFINES_SVH
`define LDR_DEFINES_SVH

// ----------------------------------------------------------------
// Bus address layout: byte address = {logical device, index, 2'b00}
// ----------------------------------------------------------------
`define LDR_ADR_W 13
`define LDR_ADR_LDN_HI 12
`define LDR_ADR_LDN_LO 10
`define LDR_ADR_IDX_HI 9
`define LDR_ADR_IDX_LO 2
`define LDR_LDN_FLOPPY 3'h0
`define LDR_LDN_PARALLEL 3'h3
`define LDR_LDN_SERIAL1 3'h4

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define LDR_IDX_MODE 8'hF0
`define LDR_IDX_OPTION 8'hF1
`define LDR_IDX_TYPE 8'hF2
`define LDR_IDX_RSVD 8'hF3
`define LDR_IDX_DRV0 8'hF4
`define LDR_IDX_DRV1 8'hF5

// ----------------------------------------------------------------
// Reset values and writable-bit masks
// ----------------------------------------------------------------
`define LDR_RST_FLOPPY_MODE 8'h0E
`define LDR_RST_OPTION 8'h00
`define LDR_RST_TYPE 8'hFF
`define LDR_RST_DRIVE 8'h00
`define LDR_RST_PARALLEL_MODE 8'h3C
`define LDR_RST_SERIAL_MODE 8'h00
`define LDR_WMASK_OPTION 8'hFC
`define LDR_WMASK_DRIVE 8'h5B
`define LDR_WMASK_SERIAL 8'h83

// ----------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------
`define LDR_FM_TRISTATE 0
`define LDR_OPT_DENS_HI 3
`define LDR_OPT_DENS_LO 2
`define LDR_OPT_MID0 4
`define LDR_OPT_MID1 5
`define LDR_OPT_BOOT_HI 7
`define LDR_OPT_BOOT_LO 6
`define LDR_DENS_FORCE1 2'h2
`define LDR_DENS_FORCE0 2'h3
`define LDR_BOOT_D0 2'h0
`define LDR_BOOT_D1 2'h1
`define LDR_TYP_A_HI 1
`define LDR_TYP_A_LO 0
`define LDR_TYP_B_HI 3
`define LDR_TYP_B_LO 2
`define LDR_DRV_TYPE_HI 1
`define LDR_DRV_TYPE_LO 0
`define LDR_DRV_RATE_HI 4
`define LDR_DRV_RATE_LO 3
`define LDR_DRV_PRECOMP 6
`define LDR_PP_MODE_HI 2
`define LDR_PP_MODE_LO 0
`define LDR_PP_THR_HI 6
`define LDR_PP_THR_LO 3
`define LDR_PP_ITYPE 7
`define LDR_SP_MIDI 0
`define LDR_SP_HS 1
`define LDR_SP_SHARE 7
`define LDR_ECR_FIFO 3'h2
`define LDR_ECR_ECP 3'h3
`define LDR_ECR_TEST 3'h6
`define LDR_IRQ_PINS 16

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LDR_CLK_MHZ 200
`define LDR_PULSE_NS 50
`define LDR_PULSE_CYC ((`LDR_PULSE_NS * `LDR_CLK_MHZ + 999) / 1000)

`endif

// File: hdl/ldr_pkg.sv
package ldr_pkg;

    typedef logic [7:0] ldr_byte_t;

    // Parallel port operating modes
    typedef enum logic [2:0] {
        PP_SPP = 3'h0,
        PP_EPP19 = 3'h1,
        PP_ECP = 3'h2,
        PP_ECP_EPP19 = 3'h3,
        PP_PRINTER = 3'h4,
        PP_EPP17 = 3'h5,
        PP_RSVD = 3'h6,
        PP_ECP_EPP17 = 3'h7
    } ldr_pp_mode_e;

    // Pulsed interrupt sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_PULSE = 2'h2
    } ldr_irq_state_e;

endpackage : ldr_pkg

// File: hdl/ldr_pp_irq.sv
`timescale 1ns/1ps
`include "ldr_defines.svh"

module ldr_pp_irq (
    // Clock and resets
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic soft_rst_i,
    input wire logic ce_i,
    // Configuration
    input wire ldr_pkg::ldr_pp_mode_e mode_i,
    input wire logic type_pulse_i,
    // Port core
    input wire logic irq_en_i,
    input wire logic [2:0] ecr_mode_i,
    input wire logic ack_n_i,
    input wire logic irq_req_i,
    // Interrupt pin
    output logic irq_o,
    output logic irq_oe_n_o
);
    import ldr_pkg::*;

    ldr_irq_state_e state;
    logic [3:0] cnt;
    logic ack_q;
    logic ack_fall;
    logic ecp_family;
    logic level_mode;
    logic pulse_mode;
    logic next_irq;
    logic next_oe_n;

    // Mode decode
    assign ecp_family = (mode_i == PP_ECP) || (mode_i == PP_ECP_EPP19)
                        || (mode_i == PP_ECP_EPP17);
    assign level_mode = ecp_family && ((ecr_mode_i == `LDR_ECR_FIFO)
                        || (ecr_mode_i == `LDR_ECR_ECP) || (ecr_mode_i == `LDR_ECR_TEST));
    assign pulse_mode = type_pulse_i && !level_mode
                        && (mode_i != PP_PRINTER) && (mode_i != PP_SPP);
    assign ack_fall = ack_q && !ack_n_i;

    // Acknowledge edge detect
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_q <= 1'b1;
        else if (ce_i)
            ack_q <= ack_n_i;
    end

    // Pulse sequencer, cleared by soft reset too
    always_ff @(posedge clk_i)
    begin
        if (rst_i || soft_rst_i)
        begin
            state <= ST_IDLE;
            cnt <= 4'h0;
        end
        else if (ce_i)
        begin
            unique case (state)
                ST_IDLE:
                begin
                    cnt <= 4'h0;
                    if (pulse_mode && irq_en_i && ack_fall)
                        state <= ST_PULSE;
                end
                ST_PULSE:
                begin
                    cnt <= cnt + 4'h1;
                    if (cnt == 4'(`LDR_PULSE_CYC - 1))
                        state <= ST_IDLE;
                end
            endcase
        end
    end

    // Pin drive selection
    always_comb
    begin
        next_irq = 1'b0;
        next_oe_n = 1'b1;
        if (!irq_en_i)
            next_oe_n = 1'b1;
        else if (level_mode)
        begin
            next_oe_n = 1'b0;
            next_irq = irq_req_i;
        end
        else if (pulse_mode)
            next_oe_n = (state != ST_PULSE);
        else
        begin
            next_oe_n = 1'b0;
            next_irq = ack_n_i;
        end
    end

    // Registered pin
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_o <= 1'b0;
            irq_oe_n_o <= 1'b1;
        end
        else if (ce_i)
        begin
            irq_o <= next_irq;
            irq_oe_n_o <= next_oe_n;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || soft_rst_i);

    sequence s_pulse_start;
        ce_i && pulse_mode && irq_en_i && ack_fall && state == ST_IDLE
        ##1 ce_i ##1 ce_i;
    endsequence

    a_pulse_low_release: assert property (
        s_pulse_start |-> (!irq_oe_n_o && !irq_o) ##[1:16] irq_oe_n_o)
        else $error("pulsed interrupt did not drive low then release");

    a_level_follows_req: assert property (
        (ce_i && irq_en_i && level_mode) |=> (!irq_oe_n_o && irq_o == $past(irq_req_i)))
        else $error("level interrupt does not follow request");

endmodule : ldr_pp_irq

// File: hdl/ldr_uart_irq.sv
`timescale 1ns/1ps
`include "ldr_defines.svh"

module ldr_uart_irq (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Sources and selections
    input wire logic share_i,
    input wire logic uart1_irq_i,
    input wire logic uart2_irq_i,
    input wire logic [3:0] uart1_sel_i,
    input wire logic [3:0] uart2_sel_i,
    // Interrupt pins
    output logic [`LDR_IRQ_PINS-1:0] irq_pin_o,
    output logic [`LDR_IRQ_PINS-1:0] irq_pin_oe_n_o
);
    import ldr_pkg::*;

    logic either;
    logic [`LDR_IRQ_PINS-1:0] sel_mask;

    assign either = uart1_irq_i || uart2_irq_i;

    // Pins that some UART has selected, for the release check only
    assign sel_mask = (`LDR_IRQ_PINS'(1) << uart1_sel_i) | (`LDR_IRQ_PINS'(1) << uart2_sel_i);

    // Per-pin routing; selection code zero means no pin
    for (genvar k = 0; k < `LDR_IRQ_PINS; k++)
    begin : g_pin
        logic hit1;
        logic hit2;
        assign hit1 = (uart1_sel_i == 4'(k)) && (uart1_sel_i != 4'h0);
        assign hit2 = (uart2_sel_i == 4'(k)) && (uart2_sel_i != 4'h0);
        always_ff @(posedge clk_i)
        begin
            if (rst_i)
            begin
                irq_pin_o[k] <= 1'b0;
                irq_pin_oe_n_o[k] <= 1'b1;
            end
            else if (ce_i)
            begin
                irq_pin_oe_n_o[k] <= !(hit1 || hit2);
                if (share_i)
                    irq_pin_o[k] <= (hit1 || hit2) && either;
                else
                    irq_pin_o[k] <= (hit1 && uart1_irq_i) || (hit2 && uart2_irq_i);
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // In share mode a request from either UART asserts both selected pins
    a_share_both_pins: assert property (
        (ce_i && share_i && (uart1_irq_i || uart2_irq_i) && uart1_sel_i != 4'h0
         && uart2_sel_i != 4'h0)
        |=> (irq_pin_o[$past(uart1_sel_i)] && irq_pin_o[$past(uart2_sel_i)]))
        else $error("shared interrupt not asserted on both pins");

    a_unused_pins_hiz: assert property (
        ce_i |=> (((~irq_pin_oe_n_o & ~$past(sel_mask)) == '0) && irq_pin_oe_n_o[0]))
        else $error("unselected interrupt pin driven");

    a_separate_lines: assert property (
        (ce_i && !share_i && uart1_sel_i != 4'h0 && uart2_sel_i != uart1_sel_i
         && !uart1_irq_i) |=> !irq_pin_o[$past(uart1_sel_i)])
        else $error("unshared pin follows the other UART");

endmodule : ldr_uart_irq

// File: hdl/ldr_option_regs.sv
`timescale 1ns/1ps
`include "ldr_defines.svh"

module ldr_option_regs (
    // Clock, resets, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic soft_rst_i,
    input wire logic ce_i,
    // Wishbone slave
    input wire logic [`LDR_ADR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Floppy pins and controls
    input wire logic density_i,
    input wire logic [1:0] media_id_i,
    output logic floppy_oe_n_o,
    output logic pp_floppy_oe_n_o,
    output logic density_o,
    output logic [1:0] media_id_o,
    output logic boot_drive0_o,
    output logic boot_drive1_o,
    output logic [1:0] drive_a_type_o,
    output logic [1:0] drive_b_type_o,
    output logic [3:0] drive_type_sel_o,
    output logic [3:0] rate_table_sel_o,
    output logic [1:0] precomp_disable_o,
    // Parallel port
    input wire logic pp_irq_en_i,
    input wire logic [2:0] pp_ecr_mode_i,
    input wire logic pp_ack_n_i,
    input wire logic pp_irq_req_i,
    output ldr_pkg::ldr_pp_mode_e pp_mode_o,
    output logic [3:0] pp_fifo_thresh_o,
    output logic pp_irq_o,
    output logic pp_irq_oe_n_o,
    // Serial ports
    input wire logic uart1_irq_i,
    input wire logic uart2_irq_i,
    input wire logic [3:0] uart1_irq_sel_i,
    input wire logic [3:0] uart2_irq_sel_i,
    output logic midi_en_o,
    output logic high_speed_o,
    output logic [`LDR_IRQ_PINS-1:0] irq_pin_o,
    output logic [`LDR_IRQ_PINS-1:0] irq_pin_oe_n_o
);
    import ldr_pkg::*;

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    ldr_byte_t floppy_mode_cfg;
    ldr_byte_t floppy_option_cfg;
    ldr_byte_t floppy_drive_type_store;
    ldr_byte_t drive_params [2];
    ldr_byte_t parallel_mode_cfg;
    ldr_byte_t serial_one_mode_cfg;

    logic [2:0] ldn;
    logic [7:0] idx;
    logic req;
    logic wr;
    ldr_byte_t wdat;
    ldr_byte_t next_rdata;
    logic floppy_sel;
    logic pp_sel;
    logic sp_sel;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    assign ldn = wb_adr_i[`LDR_ADR_LDN_HI:`LDR_ADR_LDN_LO];
    assign idx = wb_adr_i[`LDR_ADR_IDX_HI:`LDR_ADR_IDX_LO];
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = req && wb_we_i && wb_sel_i[0];
    assign wdat = wb_dat_i[7:0];
    assign floppy_sel = (ldn == `LDR_LDN_FLOPPY);
    assign pp_sel = (ldn == `LDR_LDN_PARALLEL);
    assign sp_sel = (ldn == `LDR_LDN_SERIAL1);

    // Acknowledge one cycle after the request, every address answered
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_ack_o <= 1'b0;
        else if (ce_i)
            wb_ack_o <= req;
    end

    // ----------------------------------------------------------------
    // Floppy registers: hard reset only, soft reset ignored
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            floppy_mode_cfg <= `LDR_RST_FLOPPY_MODE;
            floppy_option_cfg <= `LDR_RST_OPTION;
            floppy_drive_type_store <= `LDR_RST_TYPE;
        end
        else if (ce_i && wr && floppy_sel)
        begin
            if (idx == `LDR_IDX_MODE)
                floppy_mode_cfg <= wdat;
            if (idx == `LDR_IDX_OPTION)
                floppy_option_cfg <= wdat & `LDR_WMASK_OPTION;
            if (idx == `LDR_IDX_TYPE)
                floppy_drive_type_store <= wdat;
        end
    end

    // Per-drive parameter registers, one per drive
    for (genvar d = 0; d < 2; d++)
    begin : g_drive
        always_ff @(posedge clk_i)
        begin
            if (rst_i)
                drive_params[d] <= `LDR_RST_DRIVE;
            else if (ce_i && wr && floppy_sel && idx == `LDR_IDX_DRV0 + 8'(d))
                drive_params[d] <= wdat & `LDR_WMASK_DRIVE;
        end
        assign drive_type_sel_o[2*d+1:2*d] =
            drive_params[d][`LDR_DRV_TYPE_HI:`LDR_DRV_TYPE_LO];
        assign rate_table_sel_o[2*d+1:2*d] =
            drive_params[d][`LDR_DRV_RATE_HI:`LDR_DRV_RATE_LO];
        assign precomp_disable_o[d] = drive_params[d][`LDR_DRV_PRECOMP];
    end

    // ----------------------------------------------------------------
    // Parallel and serial mode registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            parallel_mode_cfg <= `LDR_RST_PARALLEL_MODE;
        else if (ce_i && wr && pp_sel && idx == `LDR_IDX_MODE)
            parallel_mode_cfg <= wdat;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            serial_one_mode_cfg <= `LDR_RST_SERIAL_MODE;
        else if (ce_i && wr && sp_sel && idx == `LDR_IDX_MODE)
            serial_one_mode_cfg <= wdat & `LDR_WMASK_SERIAL;
    end

    // ----------------------------------------------------------------
    // Read path; unmapped and reserved indices return zero
    // ----------------------------------------------------------------
    always_comb
    begin
        next_rdata = 8'h00;
        if (floppy_sel)
        begin
            unique case (idx)
                `LDR_IDX_MODE: next_rdata = floppy_mode_cfg;
                `LDR_IDX_OPTION: next_rdata = floppy_option_cfg;
                `LDR_IDX_TYPE: next_rdata = floppy_drive_type_store;
                `LDR_IDX_RSVD: next_rdata = 8'h00;
                `LDR_IDX_DRV0: next_rdata = drive_params[0];
                `LDR_IDX_DRV1: next_rdata = drive_params[1];
                default: next_rdata = 8'h00;
            endcase
        end
        else if (pp_sel && idx == `LDR_IDX_MODE)
            next_rdata = parallel_mode_cfg;
        else if (sp_sel && idx == `LDR_IDX_MODE)
            next_rdata = serial_one_mode_cfg;
    end

    // Read data held in a register, upper bits zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_dat_o <= 32'h0000_0000;
        else if (ce_i && req && !wb_we_i)
            wb_dat_o <= {24'h00_0000, next_rdata};
    end

    // ----------------------------------------------------------------
    // Floppy pin shaping
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            floppy_oe_n_o <= 1'b1;
            pp_floppy_oe_n_o <= 1'b1;
            density_o <= 1'b0;
            media_id_o <= 2'h0;
        end
        else if (ce_i)
        begin
            // Only bit 0 gates both floppy pin groups; bits 6, 7 never touch them
            floppy_oe_n_o <= floppy_mode_cfg[`LDR_FM_TRISTATE];
            pp_floppy_oe_n_o <= floppy_mode_cfg[`LDR_FM_TRISTATE];
            unique case (floppy_option_cfg[`LDR_OPT_DENS_HI:`LDR_OPT_DENS_LO])
                `LDR_DENS_FORCE1: density_o <= 1'b1;
                `LDR_DENS_FORCE0: density_o <= 1'b0;
                default: density_o <= density_i;
            endcase
            media_id_o[0] <= media_id_i[0] ^ floppy_option_cfg[`LDR_OPT_MID0];
            media_id_o[1] <= media_id_i[1] ^ floppy_option_cfg[`LDR_OPT_MID1];
        end
    end

    // Boot drive and drive type outputs
    assign boot_drive0_o =
        (floppy_option_cfg[`LDR_OPT_BOOT_HI:`LDR_OPT_BOOT_LO] == `LDR_BOOT_D0);
    assign boot_drive1_o =
        (floppy_option_cfg[`LDR_OPT_BOOT_HI:`LDR_OPT_BOOT_LO] == `LDR_BOOT_D1);
    assign drive_a_type_o = floppy_drive_type_store[`LDR_TYP_A_HI:`LDR_TYP_A_LO];
    assign drive_b_type_o = floppy_drive_type_store[`LDR_TYP_B_HI:`LDR_TYP_B_LO];

    // Parallel and serial mode outputs
    assign pp_mode_o =
        ldr_pp_mode_e'(parallel_mode_cfg[`LDR_PP_MODE_HI:`LDR_PP_MODE_LO]);
    assign pp_fifo_thresh_o = parallel_mode_cfg[`LDR_PP_THR_HI:`LDR_PP_THR_LO];
    assign midi_en_o = serial_one_mode_cfg[`LDR_SP_MIDI];
    assign high_speed_o = serial_one_mode_cfg[`LDR_SP_HS];

    // ----------------------------------------------------------------
    // Interrupt steering
    // ----------------------------------------------------------------
    ldr_pp_irq i_ldr_pp_irq (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .soft_rst_i(soft_rst_i),
        .ce_i(ce_i),
        .mode_i(pp_mode_o),
        .type_pulse_i(parallel_mode_cfg[`LDR_PP_ITYPE]),
        .irq_en_i(pp_irq_en_i),
        .ecr_mode_i(pp_ecr_mode_i),
        .ack_n_i(pp_ack_n_i),
        .irq_req_i(pp_irq_req_i),
        .irq_o(pp_irq_o),
        .irq_oe_n_o(pp_irq_oe_n_o)
    );

    ldr_uart_irq i_ldr_uart_irq (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .share_i(serial_one_mode_cfg[`LDR_SP_SHARE]),
        .uart1_irq_i(uart1_irq_i),
        .uart2_irq_i(uart2_irq_i),
        .uart1_sel_i(uart1_irq_sel_i),
        .uart2_sel_i(uart2_irq_sel_i),
        .irq_pin_o(irq_pin_o),
        .irq_pin_oe_n_o(irq_pin_oe_n_o)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_read_rsvd;
        ce_i && req && !wb_we_i && floppy_sel && idx == `LDR_IDX_RSVD;
    endsequence

    a_wb_ack_single: assert property (
        (ce_i && req) |=> (wb_ack_o ##1 (!wb_ack_o || !$past(ce_i))))
        else $error("bus acknowledge not a single cycle");

    a_hard_reset_defaults: assert property (
        $past(rst_i) |-> (floppy_mode_cfg == `LDR_RST_FLOPPY_MODE
        && floppy_drive_type_store == `LDR_RST_TYPE
        && parallel_mode_cfg == `LDR_RST_PARALLEL_MODE
        && serial_one_mode_cfg == `LDR_RST_SERIAL_MODE))
        else $error("registers not at defaults after hard reset");

    a_soft_reset_keeps: assert property (
        (soft_rst_i && !(ce_i && wr)) |=> $stable(floppy_mode_cfg)
        && $stable(parallel_mode_cfg) && $stable(drive_params[1]))
        else $error("soft reset changed a configuration register");

    a_rsvd_reads_zero: assert property (
        s_read_rsvd |=> (wb_ack_o && wb_dat_o == 32'h0000_0000))
        else $error("reserved index read non-zero");

    a_density_forced: assert property (
        (ce_i && floppy_option_cfg[`LDR_OPT_DENS_HI:`LDR_OPT_DENS_LO] == `LDR_DENS_FORCE1)
        |=> density_o)
        else $error("density not forced high");

    a_media_invert: assert property (
        (ce_i && !rst_i) |=> (media_id_o == ($past(media_id_i)
        ^ $past(floppy_option_cfg[`LDR_OPT_MID1:`LDR_OPT_MID0]))))
        else $error("media ID polarity wrong");

    a_drive_rsvd_zero: assert property (
        ((drive_params[0] | drive_params[1]) & ~`LDR_WMASK_DRIVE) == 8'h00)
        else $error("read-only drive bits set");

    a_floppy_tristate: assert property (
        (ce_i && floppy_mode_cfg[`LDR_FM_TRISTATE]) |=> (floppy_oe_n_o && pp_floppy_oe_n_o))
        else $error("floppy outputs not released");

    a_write_lands: assert property (
        (ce_i && wr && floppy_sel && idx == `LDR_IDX_DRV1)
        |=> (precomp_disable_o[1] == $past(wdat[`LDR_DRV_PRECOMP])))
        else $error("second drive write not applied");

    a_boot_none_sel: assert property (
        floppy_option_cfg[`LDR_OPT_BOOT_HI] |-> (!boot_drive0_o && !boot_drive1_o))
        else $error("boot drive selected for reserved code");

    a_pp_type_ignored: assert property (
        (ce_i && pp_irq_en_i && (pp_mode_o == PP_PRINTER || pp_mode_o == PP_SPP))
        |=> (!pp_irq_oe_n_o && pp_irq_o == $past(pp_ack_n_i)))
        else $error("interrupt type acted in printer or SPP mode");

    a_serial_rsvd_zero: assert property (
        (serial_one_mode_cfg & ~`LDR_WMASK_SERIAL) == 8'h00)
        else $error("reserved serial mode bits set");

endmodule : ldr_option_regs

// File: tb/test_ldr_option_regs.sv
`timescale 1ns/1ps
module test_ldr_option_regs;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic soft_rst_i = 1'b0;
    logic [12:0] adr = 13'h0;
    logic [31:0] wdat = 32'h0;
    logic we = 1'b0;
    logic stb = 1'b0;
    logic [1:0] mid_i = 2'h1;
    logic u1_irq = 1'b1;
    logic u2_irq = 1'b0;
    logic ce = 1'b1;
    logic pp_en = 1'b0;
    logic [2:0] ecr = 3'h0;
    logic pp_ack_n = 1'b1;
    logic pp_irq;
    logic pp_oe_n;
    logic [31:0] rdat;
    logic ack;
    logic fl_oe_n;
    logic dens;
    logic [1:0] mid_o;
    logic boot0;
    logic boot1;
    logic [1:0] pcd;
    logic [15:0] pin;
    logic [15:0] pin_oe_n;
    logic [7:0] q;
    int mismatches = 0;
    int checks_done = 0;
    localparam logic [12:0] ADR [8] = '{13'h3C0, 13'h3C4, 13'h3C8, 13'h3CC, 13'h3D0,
        13'h3D4, 13'hFC0, 13'h13C0};
    localparam logic [7:0] RST [8] = '{8'h0E, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h3C, 8'h00};
    localparam logic [7:0] MSK [8] = '{8'hFF, 8'hFC, 8'hFF, 8'h00, 8'h5B, 8'h5B, 8'hFF, 8'h83};

    ldr_option_regs i_ldr_option_regs (.clk_i(clk_i), .rst_i(rst_i), .soft_rst_i(soft_rst_i),
        .ce_i(ce), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_we_i(we),
        .wb_cyc_i(stb), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack), .density_i(1'b1),
        .media_id_i(mid_i), .floppy_oe_n_o(fl_oe_n), .pp_floppy_oe_n_o(), .density_o(dens),
        .media_id_o(mid_o), .boot_drive0_o(boot0), .boot_drive1_o(boot1), .drive_a_type_o(),
        .drive_b_type_o(), .drive_type_sel_o(), .rate_table_sel_o(), .precomp_disable_o(pcd),
        .pp_irq_en_i(pp_en), .pp_ecr_mode_i(ecr), .pp_ack_n_i(pp_ack_n), .pp_irq_req_i(u2_irq),
        .pp_mode_o(), .pp_fifo_thresh_o(), .pp_irq_o(pp_irq), .pp_irq_oe_n_o(pp_oe_n),
        .uart1_irq_i(u1_irq),
        .uart2_irq_i(u2_irq), .uart1_irq_sel_i(4'h3), .uart2_irq_sel_i(4'h5), .midi_en_o(),
        .high_speed_o(), .irq_pin_o(pin), .irq_pin_oe_n_o(pin_oe_n));

    // Clock at 200 MHz
    initial
    begin
        forever #2.5 clk_i = ~clk_i;
    end

    task results;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results

    task cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask : cmp

    // One classic Wishbone cycle, held until ack is sampled
    task wb(input logic [12:0] a, input logic w, input logic [7:0] d);
        int n;
        @(posedge clk_i);
        adr <= a;
        we <= w;
        wdat <= {24'h0, d};
        stb <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1)
            cmp("ack", 32'h1, 32'h0);
        q = rdat[7:0];
        stb <= 1'b0;
    endtask : wb

    task defaults;
        for (int i = 0; i < 8; i++)
        begin
            wb(ADR[i], 1'b0, 8'h00);
            cmp("default", {24'h0, RST[i]}, {24'h0, q});
        end
    endtask : defaults

    task settle;
        repeat (3) @(posedge clk_i);
    endtask : settle

    // Watchdog
    initial
    begin
        repeat (5000) @(posedge clk_i);
        mismatches++;
        results();
    end

    // Test sequence
    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        defaults();
        wb(13'h3E0, 1'b0, 8'h00);
        cmp("unmapped", 32'h0, {24'h0, q});
        $display("defaults done");
        for (int i = 0; i < 8; i++)
        begin
            wb(ADR[i], 1'b1, 8'hFF);
            wb(ADR[i], 1'b0, 8'h00);
            cmp("mask", {24'h0, MSK[i]}, {24'h0, q});
        end
        settle();
        // Packed as oe_n, density, media id, boot0, boot1, precomp disable
        cmp("floppy", 32'hA3, {fl_oe_n, dens, mid_o, boot0, boot1, pcd});
        cmp("irq", 32'h28, {16'h0, pin});
        cmp("irq_oe", 32'hFFD7, {16'h0, pin_oe_n});
        soft_rst_i <= 1'b1;
        settle();
        soft_rst_i <= 1'b0;
        wb(ADR[0], 1'b0, 8'h00);
        cmp("soft", 32'hFF, {24'h0, q});
        $display("masks done");
        wb(ADR[0], 1'b1, 8'h0E);
        wb(ADR[1], 1'b1, 8'h48);
        wb(ADR[7], 1'b1, 8'h00);
        settle();
        cmp("floppy2", 32'h15, {fl_oe_n, dens, mid_o, boot0, boot1});
        cmp("irq2", 32'h08, {16'h0, pin});
        $display("pins done");
        u1_irq <= 1'b0;
        u2_irq <= 1'b1;
        pp_en <= 1'b1;
        ecr <= 3'h3;
        settle();
        cmp("irq3", 32'h20, {16'h0, pin});
        cmp("pp_level", 32'h1, {pp_oe_n, pp_irq});
        ecr <= 3'h0;
        pp_ack_n <= 1'b0;
        settle();
        cmp("pp_pulse", 32'h0, {pp_oe_n, pp_irq});
        repeat (8) @(posedge clk_i);
        cmp("pp_hold", 32'h0, {pp_oe_n, pp_irq});
        repeat (4) @(posedge clk_i);
        cmp("pp_release", 32'h2, {pp_oe_n, pp_irq});
        pp_ack_n <= 1'b1;
        wb(ADR[6], 1'b1, 8'h84);
        settle();
        cmp("pp_printer", 32'h1, {pp_oe_n, pp_irq});
        pp_en <= 1'b0;
        settle();
        cmp("pp_off", 32'h2, {pp_oe_n, pp_irq});
        ce <= 1'b0;
        mid_i <= 2'h2;
        settle();
        cmp("freeze", 32'h1, {30'h0, mid_o});
        ce <= 1'b1;
        settle();
        cmp("thaw", 32'h2, {30'h0, mid_o});
        $display("interrupts done");
        rst_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        defaults();
        $display("hard reset done");
        results();
    end
endmodule : test_ldr_option_regs
